// file: hw/limit_regs_pkg.sv
// constants for the current-warning and over-temperature limit registers
package limit_regs_pkg;
  // command codes
  localparam logic [7:0] CMD_IOUT_WARN = 8'h46;
  localparam logic [7:0] CMD_OT_FAULT = 8'h4f;
  localparam logic [7:0] PHASE_ALL = 8'hff;
  // field layout
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int RSV_MSB = 10;
  localparam int RSV_LSB = 6;
  localparam int MANT_MSB = 5;
  localparam logic [4:0] IOUT_EXP = 5'h00;
  localparam logic [4:0] OT_EXP = 5'h02;
  localparam int OT_LSB_SHIFT = 2;
  // reset mantissas (current: hardware setting 0 restore value; over-temperature: setting 6 restore value)
  localparam logic [5:0] IOUT_MANT_RST = 6'h05;
  localparam logic [5:0] OT_MANT_RST = 6'h24;
  // current binning: below 8 is 5 A, then 5 A per five codes, 55 A cap
  localparam logic [5:0] IOUT_FIRST_EDGE = 6'h08;
  localparam logic [5:0] IOUT_TOP_EDGE = 6'h35;
  localparam logic [5:0] IOUT_BAND = 6'h05;
  localparam logic [7:0] AMP_STEP = 8'h05;
  localparam logic [7:0] AMP_MAX = 8'h37;
  localparam logic [5:0] MANT_MAX = 6'h3f;
  // three-phase stack table, upper bounds of each band
  localparam int STACK3_BANDS = 10;
  localparam logic [7:0] STACK3_EDGE [STACK3_BANDS] = '{
    8'h17, 8'h26, 8'h35, 8'h44, 8'h53,
    8'h62, 8'h71, 8'h80, 8'h8f, 8'h9e};
  // fixed restore mantissas per hardware setting
  localparam int IOUT_SETTINGS = 11;
  localparam int OT_SETTINGS = 8;
  localparam logic [5:0] OT_RESTORE [OT_SETTINGS] = '{
    6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h22, 6'h23, 6'h24, 6'h25};
  // phase counts
  localparam logic [2:0] PH_TWO = 3'h2;
  localparam logic [2:0] PH_THREE = 3'h3;
  localparam logic [2:0] PH_FOUR = 3'h4;
endpackage

// file: hw/current_temp_limit_registers.sv
// limit register bank: current warning and over-temperature fault thresholds
`timescale 1ns/1ps
`default_nettype none

module current_temp_limit_registers
  import limit_regs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] wr_data,
  input wire logic phased,
  input wire logic [7:0] phase_sel,
  input wire logic [2:0] phase_count,
  input wire logic is_primary,
  input wire logic restore_stb,
  input wire logic [3:0] restore_setting,
  input wire logic iout_valid,
  input wire logic [7:0] iout_avg,
  input wire logic temp_valid,
  input wire logic [7:0] die_temp,
  input wire logic clear_cml,
  input wire logic clear_ivd,
  output logic ack,
  output logic nack,
  output logic rd_valid,
  output logic rd_drive,
  output logic [15:0] rd_data,
  output logic cml_flag,
  output logic ivd_flag,
  output logic iout_warn,
  output logic ot_fault
);

  // bin a mantissa into the applied current level in amps
  function automatic logic [7:0] bin_amps(input logic [5:0] m);
    logic [5:0] band;
    band = 6'h00;
    if (m < IOUT_FIRST_EDGE) begin
      bin_amps = AMP_STEP;
    end else if (m >= IOUT_TOP_EDGE) begin
      bin_amps = AMP_MAX;
    end else begin
      band = (m - IOUT_FIRST_EDGE) / IOUT_BAND;
      bin_amps = AMP_STEP * ({2'b00, band} + 8'h02);
    end
  endfunction

  // clamp a wide level into the six-bit mantissa field
  function automatic logic [5:0] sat6(input logic [8:0] v);
    sat6 = (v > {3'b000, MANT_MAX}) ? MANT_MAX : v[5:0];
  endfunction

  logic [5:0] iout_mant_r, iout_mant_nxt;
  logic [5:0] ot_mant_r, ot_mant_nxt;
  logic [7:0] iout_thr_r, ot_thr_r;
  logic ack_r, nack_r, rd_valid_r, rd_drive_r;
  logic [15:0] rd_data_r;
  logic cml_r, ivd_r, iout_warn_r, ot_fault_r;

  // command decode
  wire sel_iout = (cmd_code == CMD_IOUT_WARN);
  wire sel_ot = (cmd_code == CMD_OT_FAULT);
  wire phase_all = phased && (phase_sel == PHASE_ALL);
  wire [8:0] stack_lvl = {1'b0, wr_data[7:0]};

  // read-only field checks; phased stack levels may use bits 7:6
  wire iout_ro_bad = phase_all
    ? (wr_data[EXP_MSB:EXP_LSB] != IOUT_EXP) || (wr_data[RSV_MSB:8] != 3'h0)
    : (wr_data[EXP_MSB:RSV_LSB] != {IOUT_EXP, 5'h00});
  wire ot_ro_bad = (wr_data[EXP_MSB:RSV_LSB] != {OT_EXP, 5'h00});
  wire wr_hit = wr_stb && (sel_iout || sel_ot);
  wire wr_bad = wr_stb && ((sel_iout && iout_ro_bad) || (sel_ot && ot_ro_bad));
  wire wr_ok = wr_hit && !wr_bad;

  // three-phase stack lookup: count the band edges passed
  logic [3:0] s3_band;
  always_comb begin
    s3_band = 4'h0;
    for (int i = 0; i < STACK3_BANDS; i++) begin
      if (wr_data[7:0] >= STACK3_EDGE[i]) begin
        s3_band = s3_band + 4'h1;
      end
    end
  end
  wire [7:0] s3_amps = AMP_STEP * ({4'h0, s3_band} + 8'h01);

  // per-phase mantissa for a phased write; three-phase amps reused as the code, two and four phases divide the level, other counts keep it undivided
  wire [8:0] lvl_two = (stack_lvl + 9'h001) >> 1;
  wire [8:0] lvl_four = (stack_lvl + 9'h002) >> 2;
  wire [5:0] phased_mant =
    (phase_count == PH_TWO) ? sat6(lvl_two) :
    (phase_count == PH_FOUR) ? sat6(lvl_four) :
    (phase_count == PH_THREE) ? s3_amps[5:0] : sat6(stack_lvl);
  wire [5:0] new_iout = phase_all ? phased_mant : wr_data[MANT_MSB:0];

  // fixed restore codes; the current table picks one code per band
  wire [5:0] iout_restore = (restore_setting < 4'(IOUT_SETTINGS))
    ? 6'(AMP_STEP * ({4'h0, restore_setting} + 8'h01)) : IOUT_MANT_RST;
  wire [5:0] ot_restore = (restore_setting < 4'(OT_SETTINGS))
    ? OT_RESTORE[restore_setting[2:0]] : OT_MANT_RST;

  // next mantissas: restore outranks a host write in the same cycle
  always_comb begin
    iout_mant_nxt = iout_mant_r;
    ot_mant_nxt = ot_mant_r;
    if (restore_stb) begin
      iout_mant_nxt = iout_restore;
      ot_mant_nxt = ot_restore;
    end else if (wr_ok && sel_iout) begin
      iout_mant_nxt = new_iout;
    end else if (wr_ok && sel_ot) begin
      ot_mant_nxt = wr_data[MANT_MSB:0];
    end
  end

  // read mux; a phased current read scales the level by the stack size
  wire [7:0] iout_amps = bin_amps(iout_mant_r);
  wire [10:0] stack_amps = 11'(iout_amps * {5'h00, phase_count});
  wire [15:0] iout_word = {IOUT_EXP, 4'h0, 1'b0, iout_mant_r};
  wire [15:0] ot_word = {OT_EXP, 5'h00, ot_mant_r};
  wire [15:0] rd_mux = sel_ot ? ot_word :
    (phase_all ? {IOUT_EXP, stack_amps} : iout_word);
  wire rd_hit = rd_stb && (sel_iout || sel_ot);
  wire rd_own = !(phase_all && sel_iout) || is_primary;

  // registers and one-cycle answers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      iout_mant_r <= IOUT_MANT_RST;
      ot_mant_r <= OT_MANT_RST;
      ack_r <= 1'b0;
      nack_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_drive_r <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      iout_mant_r <= iout_mant_nxt;
      ot_mant_r <= ot_mant_nxt;
      ack_r <= wr_ok;
      nack_r <= wr_bad;
      rd_valid_r <= rd_hit;
      rd_drive_r <= rd_hit && rd_own;
      rd_data_r <= (rd_hit && rd_own) ? rd_mux : 16'h0000;
    end
  end

  // sticky fault flags; a new set beats a same-cycle clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cml_r <= 1'b0;
      ivd_r <= 1'b0;
    end else begin
      cml_r <= wr_bad || (cml_r && !clear_cml);
      ivd_r <= wr_bad || (ivd_r && !clear_ivd);
    end
  end

  // applied thresholds latched a cycle behind the mantissas, so a sample on the edge after a write still meets the old threshold
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      iout_thr_r <= AMP_STEP;
      ot_thr_r <= {OT_MANT_RST, 2'b00};
      iout_warn_r <= 1'b0;
      ot_fault_r <= 1'b0;
    end else begin
      iout_thr_r <= bin_amps(iout_mant_r);
      ot_thr_r <= {ot_mant_r, 2'b00};
      if (iout_valid) begin
        iout_warn_r <= (iout_avg >= iout_thr_r);
      end
      if (temp_valid) begin
        ot_fault_r <= (die_temp >= ot_thr_r);
      end
    end
  end

  assign ack = ack_r;
  assign nack = nack_r;
  assign rd_valid = rd_valid_r;
  assign rd_drive = rd_drive_r;
  assign rd_data = rd_data_r;
  assign cml_flag = cml_r;
  assign ivd_flag = ivd_r;
  assign iout_warn = iout_warn_r;
  assign ot_fault = ot_fault_r;

  // checks
  property p_warn_cmp;
    @(posedge clock) disable iff (reset)
      iout_valid |=> (iout_warn == ($past(iout_avg) >= $past(iout_thr_r)));
  endproperty
  a_warn_cmp: assert property (p_warn_cmp) else $error("warn mismatch");
  property p_exp_zero;
    @(posedge clock) disable iff (reset)
      rd_hit && sel_iout && !phase_all && rd_own
      |=> rd_data[15:6] == 10'h000;
  endproperty
  a_exp_zero: assert property (p_exp_zero) else $error("ro bits nonzero");
  // plain reads of either register: reserved field always zero
  property p_rsv;
    @(posedge clock) disable iff (reset)
      rd_hit && rd_own && !(phase_all && sel_iout)
      |=> rd_data[RSV_MSB:RSV_LSB] == 5'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_store;
    @(posedge clock) disable iff (reset)
      wr_ok && sel_iout && !phase_all && !restore_stb
      |=> iout_mant_r == $past(wr_data[MANT_MSB:0]);
  endproperty
  a_store: assert property (p_store) else $error("mantissa lost");
  property p_bin;
    @(posedge clock) disable iff (reset)
      iout_mant_r < IOUT_FIRST_EDGE |=> iout_thr_r == AMP_STEP;
  endproperty
  a_bin: assert property (p_bin) else $error("bin edge wrong");
  property p_nack;
    @(posedge clock) disable iff (reset)
      wr_bad |=> nack && !ack && cml_flag && ivd_flag && $stable(iout_mant_r);
  endproperty
  a_nack: assert property (p_nack) else $error("bad write not nacked");
  property p_two;
    @(posedge clock) disable iff (reset)
      wr_ok && sel_iout && phase_all && phase_count == PH_TWO && !restore_stb
      && wr_data[7:0] == 8'h28 |=> iout_mant_r == 6'h14;
  endproperty
  a_two: assert property (p_two) else $error("two-phase split wrong");
  property p_four;
    @(posedge clock) disable iff (reset)
      wr_ok && sel_iout && phase_all && phase_count == PH_FOUR && !restore_stb
      && wr_data[7:0] == 8'h64 |=> iout_mant_r == 6'h19;
  endproperty
  a_four: assert property (p_four) else $error("four-phase split wrong");
  property p_silent;
    @(posedge clock) disable iff (reset)
      rd_stb && sel_iout && phase_all && !is_primary |=> rd_valid && !rd_drive;
  endproperty
  a_silent: assert property (p_silent) else $error("secondary drove");
  property p_ot;
    @(posedge clock) disable iff (reset)
      temp_valid ##1 !temp_valid |-> ot_fault == ($past(die_temp) >= $past(ot_thr_r));
  endproperty
  a_ot: assert property (p_ot) else $error("ot compare wrong");
  c_nack: cover property (@(posedge clock) disable iff (reset) wr_bad);
  c_phread: cover property (@(posedge clock) disable iff (reset)
    rd_hit && phase_all && is_primary);
  c_warn: cover property (@(posedge clock) disable iff (reset) $rose(iout_warn));
  c_ot: cover property (@(posedge clock) disable iff (reset) $rose(ot_fault));

endmodule

`default_nettype wire

// file: testbench/pmbus_host_model.sv
// host model: pmbus word reads and writes as decoded strobes
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  input wire logic clock,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] cmd_code,
  output logic [15:0] wr_data,
  output logic phased,
  output logic [7:0] phase_sel
);
  // idle bus at time zero
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    cmd_code = 8'h00;
    wr_data = 16'h0000;
    phased = 1'b0;
    phase_sel = 8'h00;
  end
  // one word, held for the taking edge; on release cmd_code, wr_data and phase_sel are scrambled
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, input logic ph);
    @(posedge clock);
    #1;
    wr_stb = w;
    rd_stb = !w;
    cmd_code = c;
    wr_data = d;
    phased = ph;
    phase_sel = ph ? 8'hff : 8'h00;
    @(posedge clock);
    #1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    cmd_code = ~c; // unmapped once inverted, never a stale command
    wr_data = ~d;
    phase_sel = ~phase_sel;
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the limit register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
  import limit_regs_pkg::*;
;
  logic clock, reset, wr_stb, rd_stb, phased, is_primary, restore_stb;
  logic iout_valid, temp_valid, clear_cml, clear_ivd;
  logic [7:0] cmd_code, phase_sel, iout_avg, die_temp;
  logic [15:0] wr_data, rd_data;
  logic [2:0] phase_count;
  logic [3:0] restore_setting;
  logic ack, nack, rd_valid, rd_drive, cml_flag, ivd_flag, iout_warn, ot_fault;
  logic [18:0] exp_q [$];
  logic [5:0] cur_m, ot_m, m;
  logic [7:0] cmd_k;
  logic [31:0] r;
  int n_errors = 0, check_count = 0, cycles = 0, k;
  integer seed = 32'hfded165c;
  current_temp_limit_registers current_temp_limit_registers_i (.clock(clock),
    .reset(reset), .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd_code(cmd_code),
    .wr_data(wr_data), .phased(phased), .phase_sel(phase_sel),
    .phase_count(phase_count), .is_primary(is_primary),
    .restore_stb(restore_stb), .restore_setting(restore_setting),
    .iout_valid(iout_valid), .iout_avg(iout_avg), .temp_valid(temp_valid),
    .die_temp(die_temp), .clear_cml(clear_cml), .clear_ivd(clear_ivd),
    .ack(ack), .nack(nack), .rd_valid(rd_valid), .rd_drive(rd_drive),
    .rd_data(rd_data), .cml_flag(cml_flag), .ivd_flag(ivd_flag),
    .iout_warn(iout_warn), .ot_fault(ot_fault));
  pmbus_host_model pmbus_host_model_i (.clock(clock), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .cmd_code(cmd_code), .wr_data(wr_data),
    .phased(phased), .phase_sel(phase_sel));
  task automatic tally_and_finish;
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // binned amps of a mantissa, 5 A bands from code 8, 55 A cap
  function automatic logic [7:0] amps(input logic [5:0] v);
    if (v < 6'h08) return 8'h05;
    if (v >= 6'h35) return 8'h37;
    return 8'h0a + 8'h05 * ((8'(v) - 8'h08) / 8'h05);
  endfunction
  task automatic wr(input logic [7:0] c, input logic [15:0] d,
    input logic ph, input logic ok);
    exp_q.push_back({ok, !ok, 17'h0});
    pmbus_host_model_i.xfer(1'b1, c, d, ph);
  endtask
  task automatic rd(input logic [7:0] c, input logic ph,
    input logic [15:0] d, input logic drv);
    exp_q.push_back({2'b00, drv, d});
    pmbus_host_model_i.xfer(1'b0, c, 16'h0000, ph);
  endtask
  // one telemetry sample; flags land on the edge that takes it
  task automatic samp(input logic [7:0] i, input logic [7:0] t);
    @(posedge clock);
    #1;
    {iout_valid, temp_valid, iout_avg, die_temp} = {2'b11, i, t};
    @(posedge clock);
    #1;
    {iout_valid, temp_valid} = 2'b00;
    check({iout_warn, ot_fault}, {i >= amps(cur_m), t >= {ot_m, 2'b00}});
  endtask
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // answers come off the queue in order; an unasked answer is an error
  always @(posedge clock) begin
    #2;
    if (ack || nack || rd_valid) begin
      if (exp_q.size() == 0) check(19'h00000, 19'h7ffff);
      else check({ack, nack, rd_drive, rd_data}, exp_q.pop_front());
    end
  end
  // main sequence
  initial begin
    {reset, is_primary, restore_stb, iout_valid, temp_valid} = 5'b11000;
    {clear_cml, clear_ivd, iout_avg, die_temp} = 18'h0;
    phase_count = 3'h1;
    restore_setting = 4'h0;
    repeat (20) @(posedge clock);
    #1;
    reset = 1'b0;
    {cur_m, ot_m} = {IOUT_MANT_RST, OT_MANT_RST};
    rd(CMD_IOUT_WARN, 1'b0, {IOUT_EXP, 5'h00, IOUT_MANT_RST}, 1'b1);
    rd(CMD_OT_FAULT, 1'b0, {OT_EXP, 5'h00, OT_MANT_RST}, 1'b1);
    for (k = 0; k < 40; k++) begin
      r = $random(seed);
      m = r[5:0];
      wr(CMD_IOUT_WARN, {10'h000, m}, 1'b0, 1'b1);
      cur_m = m;
      rd(CMD_IOUT_WARN, 1'b0, {10'h000, m}, 1'b1);
      samp(amps(m) - 8'h01, 8'h00);
      samp(amps(m), 8'h00);
      wr(CMD_OT_FAULT, {OT_EXP, 5'h00, r[11:6]}, 1'b0, 1'b1);
      ot_m = r[11:6];
      samp(8'h00, {ot_m, 2'b00} - 8'h01);
      samp(8'h00, {ot_m, 2'b00});
    end
    // read-only bits touched: refused, dropped, both flags raised
    for (k = 0; k < 3; k++) begin
      cmd_k = k == 2 ? CMD_OT_FAULT : CMD_IOUT_WARN;
      wr(cmd_k, k == 0 ? 16'h0055 : (k == 1 ? 16'h0815 : 16'h1055), 1'b0,
        1'b0);
      @(posedge clock);
      #1;
      check({cml_flag, ivd_flag}, 2'b11);
      rd(cmd_k, 1'b0, k == 2 ? {OT_EXP, 5'h00, ot_m} : {10'h000, cur_m},
        1'b1);
      {clear_cml, clear_ivd} = 2'b11;
      @(posedge clock);
      #1;
      {clear_cml, clear_ivd} = 2'b00;
      check({cml_flag, ivd_flag}, 2'b00);
    end
    // stack writes for two, four and three phases, then stack reads
    for (k = 0; k < 3; k++) begin
      phase_count = k == 0 ? PH_TWO : (k == 1 ? PH_FOUR : PH_THREE);
      m = k == 1 ? 6'h19 : 6'h14;
      wr(CMD_IOUT_WARN, k == 0 ? 16'h0028 : (k == 1 ? 16'h0064 : 16'h003c),
        1'b1, 1'b1);
      cur_m = m;
      rd(CMD_IOUT_WARN, 1'b0, {10'h000, m}, 1'b1);
      rd(CMD_IOUT_WARN, 1'b1, {5'h00, 11'(amps(m) * phase_count)}, 1'b1);
      is_primary = 1'b0;
      rd(CMD_IOUT_WARN, 1'b1, 16'h0000, 1'b0);
      is_primary = 1'b1;
    end
    // restore of setting 3 loads its fixed mantissas
    restore_setting = 4'h3;
    restore_stb = 1'b1;
    @(posedge clock);
    #1;
    restore_stb = 1'b0;
    rd(CMD_IOUT_WARN, 1'b0, 16'h0014, 1'b1);
    rd(CMD_OT_FAULT, 1'b0, {OT_EXP, 5'h00, 6'h20}, 1'b1);
    // restored codes must also drive the applied thresholds
    {cur_m, ot_m} = {6'h14, 6'h20};
    samp(8'h14, 8'h7f);
    repeat (3) @(posedge clock);
    if (exp_q.size() != 0) check(19'h00001, 19'h00000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
